// file: aocc_defs.svh
// Constants for the analog output channel control block
`ifndef AOCC_DEFS_SVH
`define AOCC_DEFS_SVH

// ==========================================================
// Register offsets
`define AOCC_CTRL_OFS 12'h000
`define AOCC_STAT_OFS 12'h004
`define AOCC_CH_BASE 12'h010
`define AOCC_CH_STRIDE 12'h020
`define AOCC_CFG_OFS 12'h000
`define AOCC_UPPER_OFS 12'h004
`define AOCC_LOWER_OFS 12'h008
`define AOCC_FAULT_OFS 12'h00c
`define AOCC_CMD_OFS 12'h010
`define AOCC_DRIVE_OFS 12'h014

// ==========================================================
// Field positions
`define AOCC_CTRL_SHORT_BIT 0
`define AOCC_CTRL_FMT_LSB 1
`define AOCC_CFG_RANGE_LSB 0
`define AOCC_CFG_UPEN_BIT 3
`define AOCC_CFG_LOEN_BIT 4
`define AOCC_CFG_FMODE_BIT 5
`define AOCC_STAT_SHORT_BIT 0
`define AOCC_STAT_UP_LSB 1
`define AOCC_STAT_LO_LSB 3
`define AOCC_STAT_COMM_BIT 5
`define AOCC_STAT_HCSOFT_BIT 6
`define AOCC_DRIVE_MODE_LSB 16

// ==========================================================
// Reset values and limits
`define AOCC_UPPER_RST 16'h03e8
`define AOCC_LOWER_RST 16'h0000
`define AOCC_FAULT_RST 16'h0000
`define AOCC_CMD_RST 16'h0000
`define AOCC_RANGE_MIN 3'h3
`define AOCC_RANGE_MAX 3'h7

`endif

// file: aocc_pkg.sv
// Types and shared functions of the analog output channel control block
package aocc_pkg;

  localparam int AOCC_NCH = 2;

  // ==========================================================
  // Enumerations
  typedef enum logic [1:0] {
    AOCC_FMT_OFFSET = 2'h0,
    AOCC_FMT_SIGNMAG = 2'h1,
    AOCC_FMT_TWOS = 2'h2,
    AOCC_FMT_LINEAR = 2'h3
  } aocc_fmt_e;

  typedef enum logic [2:0] {
    AOCC_RNG_0_10V = 3'h3,
    AOCC_RNG_0_5V = 3'h4,
    AOCC_RNG_1_5V = 3'h5,
    AOCC_RNG_0_20MA = 3'h6,
    AOCC_RNG_4_20MA = 3'h7
  } aocc_range_e;

  typedef enum logic [1:0] {
    AOCC_RUN = 2'b00,
    AOCC_HOLD = 2'b01,
    AOCC_FAULT = 2'b11
  } aocc_mode_e;

  // ==========================================================
  // Carriers
  typedef struct packed {
    aocc_range_e range;
    logic upper_en;
    logic lower_en;
    logic fault_mode;
    logic signed [15:0] upper;
    logic signed [15:0] lower;
    logic signed [15:0] fault;
  } aocc_ch_cfg_s;

  typedef struct packed {
    logic hit;
    logic glob;
    logic [0:0] ch;
    logic [11:0] ofs;
  } aocc_dec_s;

  // ==========================================================
  // Command value to signed output value
  function automatic logic signed [15:0] aocc_decode(input aocc_fmt_e fmt,
                                                    input logic [15:0] raw);
    logic [15:0] mag;
    mag = {1'b0, raw[14:0]};
    unique case (fmt)
      AOCC_FMT_OFFSET: aocc_decode = {~raw[15], raw[14:0]};
      AOCC_FMT_SIGNMAG: aocc_decode = raw[15] ? 16'(16'h0000 - mag) : mag;
      AOCC_FMT_TWOS: aocc_decode = raw;
      AOCC_FMT_LINEAR: aocc_decode = raw;
    endcase
  endfunction : aocc_decode

endpackage : aocc_pkg

// file: aocc_apb.sv
// APB slave handshake for the analog output channel control block
`timescale 1ns/1ps
`default_nettype none
module aocc_apb
  import aocc_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic hit,
  input wire logic [31:0] rdata,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  output logic wr_en
);

  logic pready_q, pready_d;
  logic pslverr_q, pslverr_d;
  logic [31:0] prdata_q, prdata_d;
  logic setup;

  // ==========================================================
  // Setup cycle captures answer
  always_comb begin
    setup = psel & ~penable;
    pready_d = setup;
    pslverr_d = setup & ~hit;
    prdata_d = prdata_q;
    if (setup) begin
      prdata_d = (hit & ~pwrite) ? rdata : 32'h0000_0000;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end else begin
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
      prdata_q <= prdata_d;
    end
  end

  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign prdata = prdata_q;
  assign wr_en = psel & penable & pready_q & pwrite & ~pslverr_q;

endmodule : aocc_apb
`default_nettype wire

// file: aocc_chan.sv
// One analog output channel: value selection and limit monitoring
`timescale 1ns/1ps
`default_nettype none
module aocc_chan
  import aocc_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire aocc_ch_cfg_s cfg,
  input wire aocc_fmt_e fmt,
  input wire logic [15:0] cmd,
  input wire logic comm_err,
  input wire logic hc_soft,
  output logic signed [15:0] drive,
  output aocc_mode_e mode,
  output logic up_err,
  output logic lo_err
);

  aocc_mode_e mode_q, mode_d;
  logic signed [15:0] drive_q, drive_d;
  logic up_err_q, up_err_d;
  logic lo_err_q, lo_err_d;

  // ==========================================================
  // Output value selection
  always_comb begin
    if (comm_err & hc_soft) begin
      mode_d = cfg.fault_mode ? AOCC_FAULT : AOCC_HOLD;
    end else begin
      mode_d = AOCC_RUN;
    end
    unique case (mode_d)
      AOCC_RUN: drive_d = aocc_decode(fmt, cmd);
      AOCC_HOLD: drive_d = drive_q;
      AOCC_FAULT: drive_d = cfg.fault;
      default: drive_d = drive_q;
    endcase
    up_err_d = cfg.upper_en & (drive_d > cfg.upper);
    lo_err_d = cfg.lower_en & (drive_d < cfg.lower);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_q <= AOCC_RUN;
      drive_q <= 16'sh0000;
      up_err_q <= 1'b0;
      lo_err_q <= 1'b0;
    end else begin
      mode_q <= mode_d;
      drive_q <= drive_d;
      up_err_q <= up_err_d;
      lo_err_q <= lo_err_d;
    end
  end

  assign drive = drive_q;
  assign mode = mode_q;
  assign up_err = up_err_q;
  assign lo_err = lo_err_q;

endmodule : aocc_chan
`default_nettype wire

// file: aocc_top.sv
// Top of the analog output channel control block: registers and channels
`include "aocc_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module aocc_top
  import aocc_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic short_det,
  input wire logic comm_err,
  input wire logic hc_soft,
  output logic [AOCC_NCH-1:0][15:0] dac_value,
  output logic [AOCC_NCH-1:0][2:0] range_sel,
  output logic short_err,
  output logic [AOCC_NCH-1:0] upper_err,
  output logic [AOCC_NCH-1:0] lower_err
);

  // ==========================================================
  // Address decoding
  function automatic aocc_dec_s aocc_addr(input logic [11:0] a);
    aocc_dec_s d;
    logic [11:0] rel;
    d = '0;
    rel = 12'(a - `AOCC_CH_BASE);
    if (a == `AOCC_CTRL_OFS || a == `AOCC_STAT_OFS) begin
      d.hit = 1'b1;
      d.glob = 1'b1;
      d.ofs = a;
    end else if (a >= `AOCC_CH_BASE &&
                 rel < 12'(`AOCC_CH_STRIDE * AOCC_NCH)) begin
      d.ch = rel[5];
      d.ofs = rel & 12'(`AOCC_CH_STRIDE - 1);
      d.hit = (d.ofs <= `AOCC_DRIVE_OFS) && (d.ofs[1:0] == 2'b00);
    end
    return d;
  endfunction : aocc_addr

  // ==========================================================
  // Declarations
  aocc_dec_s dec;
  logic wr_en;
  logic [31:0] rdata;
  logic short_mon_q, short_mon_d;
  aocc_fmt_e fmt_q, fmt_d;
  aocc_ch_cfg_s cfg_q [AOCC_NCH];
  aocc_ch_cfg_s cfg_d [AOCC_NCH];
  logic [15:0] cmd_q [AOCC_NCH];
  logic [15:0] cmd_d [AOCC_NCH];
  logic short_err_q, short_err_d;
  logic signed [15:0] drive [AOCC_NCH];
  aocc_mode_e mode [AOCC_NCH];
  logic [AOCC_NCH-1:0] up_err;
  logic [AOCC_NCH-1:0] lo_err;
  logic [2:0] new_range;
  logic [31:0] stat;

  assign dec = aocc_addr(paddr);

  // ==========================================================
  // Bus slave
  aocc_apb u_apb (
    .pclk(pclk),
    .presetn(presetn),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .hit(dec.hit),
    .rdata(rdata),
    .pready(pready),
    .prdata(prdata),
    .pslverr(pslverr),
    .wr_en(wr_en)
  );

  // ==========================================================
  // Unit control register
  always_comb begin
    short_mon_d = short_mon_q;
    fmt_d = fmt_q;
    if (wr_en && dec.glob && dec.ofs == `AOCC_CTRL_OFS) begin
      short_mon_d = pwdata[`AOCC_CTRL_SHORT_BIT];
      fmt_d = aocc_fmt_e'(pwdata[`AOCC_CTRL_FMT_LSB +: 2]);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      short_mon_q <= 1'b0;
      fmt_q <= AOCC_FMT_OFFSET;
    end else begin
      short_mon_q <= short_mon_d;
      fmt_q <= fmt_d;
    end
  end

  // ==========================================================
  // Channel registers
  always_comb begin
    new_range = pwdata[`AOCC_CFG_RANGE_LSB +: 3];
    for (int i = 0; i < AOCC_NCH; i++) begin
      cfg_d[i] = cfg_q[i];
      cmd_d[i] = cmd_q[i];
      if (wr_en && !dec.glob && int'(dec.ch) == i) begin
        unique case (dec.ofs)
          `AOCC_CFG_OFS: begin
            if (new_range >= `AOCC_RANGE_MIN && new_range <= `AOCC_RANGE_MAX) begin
              cfg_d[i].range = aocc_range_e'(new_range);
            end
            cfg_d[i].upper_en = pwdata[`AOCC_CFG_UPEN_BIT];
            cfg_d[i].lower_en = pwdata[`AOCC_CFG_LOEN_BIT];
            cfg_d[i].fault_mode = pwdata[`AOCC_CFG_FMODE_BIT];
          end
          `AOCC_UPPER_OFS: cfg_d[i].upper = pwdata[15:0];
          `AOCC_LOWER_OFS: cfg_d[i].lower = pwdata[15:0];
          `AOCC_FAULT_OFS: cfg_d[i].fault = pwdata[15:0];
          `AOCC_CMD_OFS: cmd_d[i] = pwdata[15:0];
          default: begin
          end
        endcase
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < AOCC_NCH; i++) begin
        cfg_q[i].range <= AOCC_RNG_0_10V;
        cfg_q[i].upper_en <= 1'b0;
        cfg_q[i].lower_en <= 1'b0;
        cfg_q[i].fault_mode <= 1'b0;
        cfg_q[i].upper <= `AOCC_UPPER_RST;
        cfg_q[i].lower <= `AOCC_LOWER_RST;
        cfg_q[i].fault <= `AOCC_FAULT_RST;
        cmd_q[i] <= `AOCC_CMD_RST;
      end
    end else begin
      for (int i = 0; i < AOCC_NCH; i++) begin
        cfg_q[i] <= cfg_d[i];
        cmd_q[i] <= cmd_d[i];
      end
    end
  end

  // ==========================================================
  // Channels
  for (genvar g = 0; g < AOCC_NCH; g++) begin : g_ch
    aocc_chan u_chan (
      .pclk(pclk),
      .presetn(presetn),
      .cfg(cfg_q[g]),
      .fmt(fmt_q),
      .cmd(cmd_q[g]),
      .comm_err(comm_err),
      .hc_soft(hc_soft),
      .drive(drive[g]),
      .mode(mode[g]),
      .up_err(up_err[g]),
      .lo_err(lo_err[g])
    );
    assign dac_value[g] = drive[g];
    assign range_sel[g] = cfg_q[g].range;
  end

  assign upper_err = up_err;
  assign lower_err = lo_err;

  // ==========================================================
  // Short circuit error
  always_comb begin
    short_err_d = short_mon_q & short_det;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      short_err_q <= 1'b0;
    end else begin
      short_err_q <= short_err_d;
    end
  end

  assign short_err = short_err_q;

  // ==========================================================
  // Read data
  always_comb begin
    stat = 32'h0000_0000;
    stat[`AOCC_STAT_SHORT_BIT] = short_err_q;
    stat[`AOCC_STAT_UP_LSB +: AOCC_NCH] = up_err;
    stat[`AOCC_STAT_LO_LSB +: AOCC_NCH] = lo_err;
    stat[`AOCC_STAT_COMM_BIT] = comm_err;
    stat[`AOCC_STAT_HCSOFT_BIT] = hc_soft;
    rdata = 32'h0000_0000;
    if (dec.glob) begin
      if (dec.ofs == `AOCC_CTRL_OFS) begin
        rdata[`AOCC_CTRL_SHORT_BIT] = short_mon_q;
        rdata[`AOCC_CTRL_FMT_LSB +: 2] = fmt_q;
      end else begin
        rdata = stat;
      end
    end else begin
      unique case (dec.ofs)
        `AOCC_CFG_OFS: begin
          rdata[`AOCC_CFG_RANGE_LSB +: 3] = cfg_q[dec.ch].range;
          rdata[`AOCC_CFG_UPEN_BIT] = cfg_q[dec.ch].upper_en;
          rdata[`AOCC_CFG_LOEN_BIT] = cfg_q[dec.ch].lower_en;
          rdata[`AOCC_CFG_FMODE_BIT] = cfg_q[dec.ch].fault_mode;
        end
        `AOCC_UPPER_OFS: rdata[15:0] = cfg_q[dec.ch].upper;
        `AOCC_LOWER_OFS: rdata[15:0] = cfg_q[dec.ch].lower;
        `AOCC_FAULT_OFS: rdata[15:0] = cfg_q[dec.ch].fault;
        `AOCC_CMD_OFS: rdata[15:0] = cmd_q[dec.ch];
        `AOCC_DRIVE_OFS: begin
          rdata[15:0] = drive[dec.ch];
          rdata[`AOCC_DRIVE_MODE_LSB +: 2] = mode[dec.ch];
        end
        default: rdata = 32'h0000_0000;
      endcase
    end
  end

endmodule : aocc_top
`default_nettype wire

// file: aocc_sva.sv
// Checker for the analog output channel control top
`timescale 1ns/1ps
`default_nettype none
module aocc_sva
  import aocc_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic short_det,
  input wire logic comm_err,
  input wire logic hc_soft,
  input wire logic [AOCC_NCH-1:0][15:0] dac_value,
  input wire logic [AOCC_NCH-1:0][2:0] range_sel,
  input wire logic short_err
);
  // ==========================================================
  // Assertions
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  sequence quiet;
    presetn && !psel && !comm_err;
  endsequence
  sequence held;
    presetn && !psel && comm_err && hc_soft;
  endsequence
  a_ready_follows: assert property (psel && !penable |=> pready)
    else $error("no pready after setup");
  a_ready_single: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_slverr_gap: assert property (pready && paddr == 12'h008 |-> pslverr)
    else $error("unmapped access not refused");
  a_err_with_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  a_read_upper_zero: assert property (pready && !pwrite && paddr != 12'h024 &&
    paddr != 12'h044 |-> prdata[31:16] == 16'h0000)
    else $error("read upper half not zero");
  a_range_legal: assert property (range_sel[0] >= 3'h3 && range_sel[1] >= 3'h3)
    else $error("range code below 3");
  a_short_cause: assert property (short_err |-> $past(short_det))
    else $error("short error without short");
  a_follow_steady: assert property (quiet [*3] |-> $stable(dac_value))
    else $error("output moved with no command");
  a_hold_steady: assert property (held [*3] |-> $stable(dac_value))
    else $error("output moved during comm error");
endmodule : aocc_sva
bind aocc_top aocc_sva i_aocc_sva (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
  .prdata, .pready, .pslverr, .short_det, .comm_err, .hc_soft, .dac_value, .range_sel,
  .short_err);
`default_nettype wire

// file: aocc_field.sv
// Field side model: short detector and bus unit status lines
`timescale 1ns/1ps
`default_nettype none
module aocc_field (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [2:0] want,
  output logic short_det,
  output logic comm_err,
  output logic hc_soft
);
  // ==========================================================
  // Status lines
  // hold clear select
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {short_det, comm_err, hc_soft} <= 3'h0;
    end else begin
      {short_det, comm_err, hc_soft} <= want;
    end
  end
endmodule : aocc_field
`default_nettype wire

// file: tb.sv
// Self-checking testbench for the analog output channel control top
`timescale 1ns/1ps
`default_nettype none
module tb;
  import aocc_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, short_det, comm_err, hc_soft, short_err, er;
  logic [2:0] want = 3'h0;
  logic [AOCC_NCH-1:0][15:0] dac_value;
  logic [AOCC_NCH-1:0][2:0] range_sel;
  logic [AOCC_NCH-1:0] upper_err, lower_err;
  int fail_count = 0, checks = 0;
  always #25 pclk = ~pclk;
  aocc_top i_aocc_top (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .short_det, .comm_err, .hc_soft, .dac_value,
    .range_sel, .short_err, .upper_err, .lower_err);
  aocc_field i_aocc_field (.pclk, .presetn, .want, .short_det, .comm_err, .hc_soft);
  // ==========================================================
  // Shared tasks
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value %s exp %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    {psel, penable} <= 2'b00;
  endtask : apb
  task automatic wt;
    repeat (3) @(posedge pclk);
  endtask : wt
  // ==========================================================
  // Scenarios
  // defaults
  task automatic t_reset;
    logic [11:0] a[5] = '{12'h000, 12'h010, 12'h014, 12'h018, 12'h01c};
    logic [31:0] e[5] = '{32'h0, 32'h3, 32'h3e8, 32'h0, 32'h0};
    chk("range", 32'(range_sel[1]), 32'h3);
    for (int i = 0; i < 5; i++) begin
      apb(1'b0, a[i], 32'h0);
      chk("reg", rd, e[i]);
    end
    chk("dac1", 32'(dac_value[1]), 32'h8000);
    apb(1'b1, 12'h008, 32'h1);
    apb(1'b0, 12'h008, 32'h0);
    chk("gap", {er, rd[30:0]}, 32'h80000000);
  endtask : t_reset
  task automatic t_format;
    logic [15:0] e[4] = '{16'h0005, 16'hfffb, 16'h8005, 16'h8005};
    apb(1'b1, 12'h020, 32'h8005);
    for (int f = 0; f < 4; f++) begin
      apb(1'b1, 12'h000, 32'(f * 2));
      wt();
      chk("fmt", 32'(dac_value[0]), 32'(e[f]));
    end
  endtask : t_format
  task automatic t_range;
    for (int r = 3; r < 8; r++) begin
      apb(1'b1, 12'h030, 32'(r));
      wt();
      chk("range", 32'(range_sel[1]), 32'(r));
    end
    apb(1'b1, 12'h030, 32'h2);
    wt();
    chk("range keep", 32'(range_sel[1]), 32'h7);
  endtask : t_range
  task automatic t_limits;
    logic [15:0] c[4] = '{16'd1051, 16'd1050, 16'd4, 16'd5};
    logic [1:0] e[4] = '{2'b10, 2'b00, 2'b01, 2'b00};
    apb(1'b1, 12'h000, 32'h4);
    apb(1'b1, 12'h014, 32'd1050);
    apb(1'b1, 12'h018, 32'd5);
    apb(1'b1, 12'h010, 32'h1b);
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, 12'h020, 32'(c[i]));
      wt();
      chk("up", 32'(upper_err[0]), 32'(e[i][1]));
      chk("lo", 32'(lower_err[0]), 32'(e[i][0]));
      apb(1'b0, 12'h004, 32'h0);
      chk("stat", rd, 32'({e[i][0], 1'b0, e[i][1], 1'b0}));
    end
    apb(1'b1, 12'h010, 32'h3);
    apb(1'b1, 12'h020, 32'd2000);
    wt();
    chk("up off", 32'(upper_err[0]), 32'h0);
  endtask : t_limits
  task automatic t_short;
    want <= 3'b100;
    wt();
    chk("short off", 32'(short_err), 32'h0);
    apb(1'b1, 12'h000, 32'h5);
    wt();
    chk("short on", 32'(short_err), 32'h1);
    apb(1'b0, 12'h004, 32'h0);
    chk("stat", 32'(rd[0]), 32'h1);
    want <= 3'b000;
    wt();
    chk("short clr", 32'(short_err), 32'h0);
  endtask : t_short
  task automatic t_comm;
    apb(1'b1, 12'h010, 32'h23);
    apb(1'b1, 12'h01c, 32'hfff9);
    want <= 3'b010;
    apb(1'b1, 12'h020, 32'd200);
    wt();
    chk("bus policy", 32'(dac_value[0]), 32'd200);
    want <= 3'b011;
    wt();
    chk("fault", 32'(dac_value[0]), 32'hfff9);
    apb(1'b0, 12'h024, 32'h0);
    chk("drive fault", rd, 32'h0003_fff9);
    apb(1'b0, 12'h004, 32'h0);
    chk("stat comm", rd, 32'h0000_0060);
    want <= 3'b000;
    apb(1'b1, 12'h010, 32'h3);
    wt();
    want <= 3'b011;
    apb(1'b1, 12'h020, 32'd300);
    wt();
    chk("hold", 32'(dac_value[0]), 32'd200);
    apb(1'b0, 12'h024, 32'h0);
    chk("drive hold", rd, 32'h0001_00c8);
    want <= 3'b000;
    wt();
    chk("resume", 32'(dac_value[0]), 32'd300);
  endtask : t_comm
  // ==========================================================
  // Sequence, watchdog and verdict
  task automatic end_of_test;
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : end_of_test
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_format();
    t_range();
    t_limits();
    t_short();
    t_comm();
    end_of_test();
  end
  initial begin
    #100us;
    fail_count++;
    end_of_test();
  end
endmodule : tb
`default_nettype wire
